// ---- verilog/swsl_pkg.sv ----
////////////////////////////////////////////////////////////////////////////////
// shared constants for the six wiper serial loader, both ends
package swsl_pkg;

  // frame layout
  localparam int CHANNELS = 6;
  localparam int SETTING_BITS = 8;
  localparam int POS_BITS = 6;
  localparam int FRAME_BITS = CHANNELS * SETTING_BITS;
  localparam int HOLD_MSB = 7;
  localparam int HOLD_LSB = 6;
  localparam logic [1:0] HOLD_CODE = 2'h3;
  localparam logic [POS_BITS-1:0] TAP_LOW = 6'h00;
  localparam logic [POS_BITS-1:0] TAP_HIGH = 6'h3F;

  // power-up values
  localparam logic [FRAME_BITS-1:0] SETTING_RESET = 48'h0000_0000_0000;
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 48'h0000_0000_0000;

  // frame counter width, enough for one 48-bit frame
  localparam int BITCNT_W = 6;
  localparam logic [BITCNT_W-1:0] LAST_BIT = 6'h2F;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int HALF_CYC_RAW = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int HALF_CYC = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;
  localparam int PHASE_W = 4;
  localparam logic [PHASE_W-1:0] HALF_LAST = 4'(HALF_CYC - 1);
  localparam logic [PHASE_W-1:0] GAP_LAST = 4'(2 * HALF_CYC - 1);

  // host side buffering
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;

endpackage

// ---- verilog/swsl_link_if.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// three wire port plus cascade return between host and device
interface swsl_link_if;
  logic portEn; // high while the port is active
  logic serData; // data toward the device
  logic serClk; // shift clock, rising edge samples
  logic cascadeOut; // bit leaving the end of the shift register

  modport dev (
    input portEn,
    input serData,
    input serClk,
    output cascadeOut
  );

  modport host (
    output portEn,
    output serData,
    output serClk,
    input cascadeOut
  );
endinterface

// ---- verilog/swsl_device.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// device end: samples the port pins on clk, shifts, applies on end of frame
module swsl_device (
  input wire logic clk,
  input wire logic resetn,
  swsl_link_if.dev link,
  output logic [swsl_pkg::FRAME_BITS-1:0] wiperSetting,
  output logic [swsl_pkg::CHANNELS-1:0] tapAtHigh,
  output logic [swsl_pkg::CHANNELS-1:0] tapAtLow,
  output logic applyPulse,
  output logic shortFrame
);
  import swsl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state of the device end
  typedef struct packed {
    logic [1:0] enSync;
    logic [1:0] dinSync;
    logic [1:0] clkSync;
    logic clkPrev;
    logic enPrev;
    logic [FRAME_BITS-1:0] shiftReg;
    logic [FRAME_BITS-1:0] setting;
    logic [BITCNT_W-1:0] bitCount;
    logic fullSeen;
    logic cascade;
    logic [CHANNELS-1:0] atHigh;
    logic [CHANNELS-1:0] atLow;
    logic applied;
    logic shortSeen;
  } swsl_dev_state_t;

  localparam swsl_dev_state_t STATE_RESET = '{
    enSync: 2'h0,
    dinSync: 2'h0,
    clkSync: 2'h0,
    clkPrev: 1'b0,
    enPrev: 1'b0,
    shiftReg: SHIFT_RESET,
    setting: SETTING_RESET,
    bitCount: '0,
    fullSeen: 1'b0,
    cascade: 1'b0,
    atHigh: '0,
    atLow: '1,
    applied: 1'b0,
    shortSeen: 1'b0
  };

  swsl_dev_state_t stateQ;
  swsl_dev_state_t stateD;

  logic portActive;
  logic clkRise;
  logic enFall;
  logic dinBit;

  //////////////////////////////////////////////////////////////////////////////
  // pin qualifiers, read only from the second synchroniser stage
  assign portActive = stateQ.enSync[1];
  assign clkRise = stateQ.clkSync[1] & ~stateQ.clkPrev;
  assign enFall = stateQ.enPrev & ~stateQ.enSync[1];
  assign dinBit = stateQ.dinSync[1];

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    stateD = stateQ;

    // two flip-flops on every pin before use
    stateD.enSync = {stateQ.enSync[0], link.portEn};
    stateD.dinSync = {stateQ.dinSync[0], link.serData};
    stateD.clkSync = {stateQ.clkSync[0], link.serClk};
    stateD.clkPrev = stateQ.clkSync[1];
    stateD.enPrev = stateQ.enSync[1];
    stateD.applied = 1'b0;

    // a new frame restarts the bit count
    if (portActive && !stateQ.enPrev) begin
      stateD.bitCount = '0;
      stateD.fullSeen = 1'b0;
    end

    // shift one bit per rising edge, new bit at the top, old bits down
    if (portActive && clkRise) begin
      stateD.shiftReg = {dinBit, stateQ.shiftReg[FRAME_BITS-1:1]};
      if (stateQ.bitCount == LAST_BIT) begin
        stateD.bitCount = '0;
        stateD.fullSeen = 1'b1;
      end else begin
        stateD.bitCount = stateQ.bitCount + 1'b1;
      end
    end

    // end of transfer: each channel takes its byte unless it holds
    if (enFall) begin
      stateD.applied = 1'b1;
      stateD.shortSeen = (stateQ.bitCount != '0) || !stateQ.fullSeen;
      for (int c = 0; c < CHANNELS; c++) begin
        if (stateQ.shiftReg[c*SETTING_BITS+HOLD_LSB +: 2] != HOLD_CODE) begin
          stateD.setting[c*SETTING_BITS +: SETTING_BITS] =
            stateQ.shiftReg[c*SETTING_BITS +: SETTING_BITS];
        end
      end
    end

    // end-of-travel flags per channel from the stored tap index
    for (int c = 0; c < CHANNELS; c++) begin
      stateD.atHigh[c] = stateD.setting[c*SETTING_BITS +: POS_BITS] == TAP_HIGH;
      stateD.atLow[c] = stateD.setting[c*SETTING_BITS +: POS_BITS] == TAP_LOW;
    end

    // cascade follows the bottom bit whatever the enable does
    stateD.cascade = stateD.shiftReg[0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register, cleared at power-up except atLow, which comes up all ones
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stateQ <= STATE_RESET;
    end else begin
      stateQ <= stateD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign link.cascadeOut = stateQ.cascade;
  assign wiperSetting = stateQ.setting;
  assign tapAtHigh = stateQ.atHigh;
  assign tapAtLow = stateQ.atLow;
  assign applyPulse = stateQ.applied;
  assign shortFrame = stateQ.shortSeen;

endmodule

// ---- verilog/swsl_host.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// frame buffer, valid and ready on both sides
module swsl_fifo #(
  parameter int WIDTH = swsl_pkg::FRAME_BITS,
  parameter int DEPTH = swsl_pkg::FIFO_DEPTH,
  parameter int AW = swsl_pkg::FIFO_AW
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } swsl_fifo_state_t;

  swsl_fifo_state_t stateQ;
  swsl_fifo_state_t stateD;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign full = (stateQ.wrPtr[AW] != stateQ.rdPtr[AW]) &&
                (stateQ.wrPtr[AW-1:0] == stateQ.rdPtr[AW-1:0]);
  assign empty = stateQ.wrPtr == stateQ.rdPtr;
  assign push = inValid & ~full;
  assign pop = outReady & ~empty;
  assign inReady = ~full;
  assign outValid = ~empty;
  assign outData = mem[stateQ.rdPtr[AW-1:0]];

  // pointer update
  always_comb begin
    stateD = stateQ;
    if (push) begin
      stateD.wrPtr = stateQ.wrPtr + 1'b1;
    end
    if (pop) begin
      stateD.rdPtr = stateQ.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stateQ <= '0;
    end else begin
      stateQ <= stateD;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[stateQ.wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// host end: sends buffered frames, divides clk into the shift clock
module swsl_host (
  input wire logic clk,
  input wire logic resetn,
  swsl_link_if.host link,
  input wire logic [swsl_pkg::FRAME_BITS-1:0] wrData,
  input wire logic wrValid,
  output logic wrReady,
  output logic [swsl_pkg::FRAME_BITS-1:0] rdData,
  output logic rdValid,
  output logic busy
);
  import swsl_pkg::*;

  typedef enum logic [2:0] {IDLE, LEAD, LOW, HIGH, TAIL, GAP} swsl_host_phase_t;

  typedef struct packed {
    swsl_host_phase_t phase;
    logic [PHASE_W-1:0] tick;
    logic [BITCNT_W-1:0] bitIdx;
    logic [FRAME_BITS-1:0] txShift;
    logic [FRAME_BITS-1:0] rxShift;
    logic [1:0] coutSync;
    logic portEn;
    logic serData;
    logic serClk;
    logic [FRAME_BITS-1:0] rdData;
    logic rdValid;
    logic busy;
  } swsl_host_state_t;

  swsl_host_state_t stateQ;
  swsl_host_state_t stateD;
  logic [FRAME_BITS-1:0] fifoData;
  logic fifoValid;
  logic fifoTake;
  logic tickDone;

  //////////////////////////////////////////////////////////////////////////////
  // frames queue here; the serial side drains one per transaction
  swsl_fifo #(
    .WIDTH(FRAME_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .inData(wrData),
    .inValid(wrValid),
    .inReady(wrReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoTake)
  );

  assign fifoTake = (stateQ.phase == IDLE) && fifoValid;
  assign tickDone = stateQ.tick == HALF_LAST;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    stateD = stateQ;
    stateD.coutSync = {stateQ.coutSync[0], link.cascadeOut};
    stateD.tick = stateQ.tick + 1'b1;
    stateD.rdValid = 1'b0;
    case (stateQ.phase)
      IDLE: begin
        stateD.tick = '0;
        if (fifoValid) begin
          stateD.txShift = fifoData;
          stateD.bitIdx = '0;
          stateD.portEn = 1'b1;
          stateD.phase = LEAD;
        end
      end
      LEAD: begin
        if (tickDone) begin
          stateD.tick = '0;
          stateD.serData = stateQ.txShift[0];
          stateD.phase = LOW;
        end
      end
      LOW: begin
        if (tickDone) begin
          stateD.tick = '0;
          stateD.serClk = 1'b1;
          stateD.rxShift = {stateQ.coutSync[1], stateQ.rxShift[FRAME_BITS-1:1]};
          stateD.txShift = {1'b0, stateQ.txShift[FRAME_BITS-1:1]};
          stateD.phase = HIGH;
        end
      end
      HIGH: begin
        if (tickDone) begin
          stateD.tick = '0;
          stateD.serClk = 1'b0;
          if (stateQ.bitIdx == LAST_BIT) begin
            stateD.phase = TAIL;
          end else begin
            stateD.bitIdx = stateQ.bitIdx + 1'b1;
            stateD.serData = stateQ.txShift[0];
            stateD.phase = LOW;
          end
        end
      end
      TAIL: begin
        if (tickDone) begin
          stateD.tick = '0;
          stateD.portEn = 1'b0;
          stateD.serData = 1'b0;
          stateD.rdData = stateQ.rxShift;
          stateD.rdValid = 1'b1;
          stateD.phase = GAP;
        end
      end
      GAP: begin
        if (stateQ.tick == GAP_LAST) begin
          stateD.tick = '0;
          stateD.phase = IDLE;
        end
      end
      default: begin
        stateD.phase = IDLE;
      end
    endcase
    // busy comes from a flop so the port does not glitch with phase decode
    stateD.busy = stateD.phase != IDLE;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stateQ <= '{phase: IDLE, default: '0};
    end else begin
      stateQ <= stateD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs from the state register
  assign link.portEn = stateQ.portEn;
  assign link.serData = stateQ.serData;
  assign link.serClk = stateQ.serClk;
  assign rdData = stateQ.rdData;
  assign rdValid = stateQ.rdValid;
  assign busy = stateQ.busy;
endmodule

// ---- testbench/swsl_link_properties.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// watches the wire between the host end and the device end
module swsl_link_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic portEn,
  input wire logic serData,
  input wire logic serClk,
  input wire logic cascadeOut
);
  typedef struct packed {
    logic clkPrev;
    logic [6:0] rises;
  } swsl_chk_t;
  swsl_chk_t chk_q;
  swsl_chk_t chk_d;

  // counts shift clock rises inside one frame
  always_comb begin
    chk_d = chk_q;
    chk_d.clkPrev = serClk;
    if (!portEn) begin
      chk_d.rises = 7'h00;
    end else if (serClk && !chk_q.clkPrev) begin
      chk_d.rises = chk_q.rises + 7'h01;
    end
  end

  // helper register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chk_q <= '0;
    end else begin
      chk_q <= chk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence highHalf;
    serClk [*4] ##1 !serClk;
  endsequence
  sequence leadGap;
    !serClk [*8] ##1 serClk;
  endsequence
  sequence tailGap;
    portEn [*4] ##1 !portEn;
  endsequence

  // shift clock shape, framing and data setup
  clk_high_half_a: assert property ($rose(serClk) |-> highHalf)
    else $error("shift clock high phase is not four cycles");
  clk_in_frame_a: assert property ($rose(serClk) |-> portEn)
    else $error("shift clock rose outside a frame");
  frame_lead_a: assert property ($rose(portEn) |-> leadGap)
    else $error("first shift clock rise not eight cycles after enable");
  data_setup_a: assert property ($rose(serClk) |-> serData == $past(serData, 3))
    else $error("data changed too close to the shift clock rise");
  frame_length_a: assert property ($fell(portEn) |-> chk_q.rises == 7'h30)
    else $error("frame did not carry 48 rises");
  frame_tail_a: assert property ($fell(serClk) && chk_q.rises == 7'h30 |-> tailGap)
    else $error("enable did not drop four cycles after last fall");
  cascade_idle_a: assert property (!portEn |=> $stable(cascadeOut))
    else $error("cascade output moved with the port inactive");
  cascade_shift_a: assert property ($changed(cascadeOut) |->
    $past(serClk, 3) || $past(serClk, 4) || $past(serClk, 5))
    else $error("cascade output moved without a shift");
endmodule

// ---- testbench/six_wiper_serial_loader_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin nCompared++; if ((gt) !== (ex)) begin failCount++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
////////////////////////////////////////////////////////////////////////////////
// both ends on one link, a second device driven by the bench
module six_wiper_serial_loader_tb_top;
  import swsl_pkg::*;
  typedef logic [FRAME_BITS-1:0] swsl_frame_t;
  logic clk, resetn, wrValid, stall, wrReady, rdValid, busy;
  logic applyPulse, shortFrame, applyPulseB, shortFrameB, expShortB;
  swsl_frame_t wrData, rdData, wiperSetting, wiperSettingB, modelW, wB, shB, prevF, frameR;
  logic [CHANNELS-1:0] tapAtHigh, tapAtLow, tapAtLowB;
  swsl_frame_t sentQ[$];
  swsl_frame_t readQ[$];
  int failCount, nCompared, applyB;
  swsl_link_if linkA();
  swsl_link_if linkB();

  swsl_host swsl_host_inst (.clk(clk), .resetn(resetn), .link(linkA.host), .wrData(wrData),
    .wrValid(wrValid), .wrReady(wrReady), .rdData(rdData), .rdValid(rdValid), .busy(busy));
  swsl_device swsl_device_inst (.clk(clk), .resetn(resetn), .link(linkA.dev),
    .wiperSetting(wiperSetting), .tapAtHigh(tapAtHigh), .tapAtLow(tapAtLow),
    .applyPulse(applyPulse), .shortFrame(shortFrame));
  swsl_device swsl_device_inst_b (.clk(clk), .resetn(resetn), .link(linkB.dev),
    .wiperSetting(wiperSettingB), .tapAtHigh(), .tapAtLow(tapAtLowB),
    .applyPulse(applyPulseB), .shortFrame(shortFrameB));
  swsl_link_properties swsl_link_properties_inst (.clk(clk), .resetn(resetn),
    .portEn(linkA.portEn), .serData(linkA.serData), .serClk(linkA.serClk),
    .cascadeOut(linkA.cascadeOut));

  ////////////////////////////////////////////////////////////////////////////////
  // reference: hold code keeps the whole byte, otherwise it loads
  function automatic swsl_frame_t applyModel(input swsl_frame_t w, input swsl_frame_t f);
    for (int c = 0; c < CHANNELS; c++) begin
      if (f[8*c+6 +: 2] != HOLD_CODE) begin
        w[8*c +: 8] = f[8*c +: 8];
      end
    end
    return w;
  endfunction

  function automatic logic [CHANNELS-1:0] tapIs(input swsl_frame_t w, input logic [5:0] t);
    tapIs = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      tapIs[c] = (w[8*c +: 6] == t);
    end
  endfunction

  // verdict and end of run
  task automatic wrapUp();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // one frame into the host buffer, held until taken
  task automatic push(input swsl_frame_t f);
    wrData = f;
    wrValid = 1'h1;
    // wrReady is settled here and holds up to the coming edge
    while (wrReady !== 1'h1) begin
      stall = 1'h1;
      wt(1);
    end
    wt(1);
    readQ.push_back(prevF);
    sentQ.push_back(f);
    prevF = f;
  endtask

  task automatic drain(input string nm);
    wrValid = 1'h0;
    for (int k = 0; k < 20000 && sentQ.size() + readQ.size() > 0; k++) begin
      @(posedge clk);
    end
    wt(10);
    `CHK("frames pending", 0, sentQ.size() + readQ.size())
    `CHK("busy", 1'h0, busy)
    $display("test %s done", nm);
  endtask

  // bench drives the second link bit by bit, rising edge samples
  task automatic wireBits(input int n, input logic [95:0] d, input logic en);
    linkB.portEn = en;
    wt(4);
    for (int i = 0; i < n; i++) begin
      linkB.serData = d[i];
      wt(4);
      linkB.serClk = 1'h1;
      if (en) begin
        shB = {d[i], shB[FRAME_BITS-1:1]};
      end
      wt(4);
      linkB.serClk = 1'h0;
    end
    wt(4);
    linkB.portEn = 1'h0;
    wt(12);
    `CHK("cascadeOutB", shB[0], linkB.cascadeOut)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // compares every applied frame and every readback
  always @(negedge clk) begin
    if (applyPulse === 1'h1 && sentQ.size() > 0) begin
      modelW = applyModel(modelW, sentQ.pop_front());
      `CHK("wiperSetting", modelW, wiperSetting)
      `CHK("tapAtHigh", tapIs(modelW, TAP_HIGH), tapAtHigh)
      `CHK("tapAtLow", tapIs(modelW, TAP_LOW), tapAtLow)
      `CHK("shortFrame", 1'h0, shortFrame)
    end
    if (rdValid === 1'h1 && readQ.size() > 0) begin
      frameR = readQ.pop_front();
      `CHK("rdData", frameR, rdData)
    end
    if (applyPulseB === 1'h1) begin
      applyB++;
      wB = applyModel(wB, shB);
      `CHK("wiperSettingB", wB, wiperSettingB)
      `CHK("shortFrameB", expShortB, shortFrameB)
      `CHK("tapAtLowB", tapIs(wB, TAP_LOW), tapAtLowB)
    end
  end

  // clock and watchdog, about three times the expected run
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    #6000000;
    failCount++;
    wrapUp();
  end

  // main sequence
  initial begin
    resetn = 1'h0;
    wrValid = 1'h0;
    wrData = '0;
    stall = 1'h0;
    linkB.portEn = 1'h0;
    linkB.serData = 1'h0;
    linkB.serClk = 1'h0;
    modelW = SETTING_RESET;
    wB = SETTING_RESET;
    shB = SHIFT_RESET;
    prevF = SHIFT_RESET;
    expShortB = 1'h0;
    void'($urandom(41060));
    wt(8);
    resetn = 1'h1;
    @(negedge clk);
    `CHK("wiperSetting", SETTING_RESET, wiperSetting)
    `CHK("tapAtLow", 6'h3F, tapAtLow)
    `CHK("tapAtHigh", 6'h00, tapAtHigh)
    $display("test reset done");
    wt(1);
    push(48'h3F81_7F00_3F0F);
    push(48'hC0FF_C0FF_C0FF);
    push(48'hC021_C0D5_3F2A);
    drain("directed");
    for (int i = 0; i < 40; i++) begin
      push(48'({$urandom(), $urandom()}));
    end
    `CHK("wrReady stall", 1'h1, stall)
    drain("fill");
    wireBits(48, {$urandom(), $urandom(), $urandom()}, 1'h0);
    `CHK("applyCount", 0, applyB)
    expShortB = 1'h1;
    wireBits(20, {$urandom(), $urandom(), $urandom()}, 1'h1);
    `CHK("applyCount", 1, applyB)
    expShortB = 1'h0;
    wireBits(96, {$urandom(), $urandom(), $urandom()}, 1'h1);
    `CHK("applyCount", 2, applyB)
    $display("test fault link done");
    resetn = 1'h0;
    wt(2);
    `CHK("wiperSetting", SETTING_RESET, wiperSetting)
    `CHK("cascadeOut", 1'h0, linkA.cascadeOut)
    resetn = 1'h1;
    modelW = SETTING_RESET;
    prevF = SHIFT_RESET;
    wt(2);
    `CHK("tapAtLow", 6'h3F, tapAtLow)
    `CHK("applyPulse", 1'h0, applyPulse)
    `CHK("wrReady", 1'h1, wrReady)
    push(48'({$urandom(), $urandom()}));
    drain("second reset");
    wrapUp();
  end
endmodule
